// ===== lpwm_pkg.sv
package lpwm_pkg;
   // ==========================================================
   // sizes
   localparam int          LPWM_CHANNELS       = 12;
   localparam int          LPWM_STEPS          = 256;
   // ==========================================================
   // register offsets
   localparam logic [7:0]  OFS_SHUTDOWN_CONTROL = 8'h00;
   localparam logic [7:0]  OFS_CHANNEL_DUTY     = 8'h04;
   localparam logic [7:0]  OFS_DUTY_LAST        = 8'h0F;
   localparam logic [7:0]  OFS_SHADOW_LOAD      = 8'h13;
   localparam logic [7:0]  OFS_CURRENT_SELECT   = 8'h17;
   localparam logic [7:0]  OFS_SELECT_LAST      = 8'h22;
   localparam logic [7:0]  OFS_GLOBAL_OUTPUT    = 8'h26;
   localparam logic [7:0]  OFS_PWM_RATE_SELECT  = 8'h27;
   localparam logic [7:0]  OFS_SOFT_RESET       = 8'h2F;
   // ==========================================================
   // field positions, trigger value and reset values
   localparam int          BIT_SOFT_OFF_N       = 0;
   localparam int          BIT_GLOBAL_OFF       = 0;
   localparam int          BIT_RATE_SELECT      = 0;
   localparam int          SCALE_WIDTH          = 6;
   localparam logic [1:0]  SCALE_ON_TOP         = 2'h1;
   localparam logic [7:0]  TRIGGER_VALUE        = 8'h00;
   localparam logic [7:0]  RESET_DUTY           = 8'h00;
   localparam logic [5:0]  RESET_SCALE          = 6'h00;
   localparam logic        RESET_SOFT_OFF_N     = 1'b0;
   localparam logic        RESET_GLOBAL_OFF     = 1'b0;
   localparam logic        RESET_RATE_SELECT    = 1'b0;
   // ==========================================================
   // timing: one pwm step lasts clk / (rate * steps), rounded down
   localparam longint      CLK_HZ               = 20000000;
   localparam longint      RATE_FAST_HZ         = 24000;
   localparam longint      RATE_SLOW_HZ         = 3600;
   localparam int          STEP_FAST_CYCLES     = int'(CLK_HZ / (RATE_FAST_HZ * LPWM_STEPS));
   localparam int          STEP_SLOW_CYCLES     = int'(CLK_HZ / (RATE_SLOW_HZ * LPWM_STEPS));
   // ==========================================================
   // state of the step counter
   typedef struct packed {
      logic [7:0] div;
      logic [7:0] cnt;
      logic       wrap;
   } lpwm_tick_state_type;
   // state of the register set and outputs
   typedef struct packed {
      logic [7:0]                        ptr;
      logic                              soft_off_n;
      logic                              global_off;
      logic                              rate_select_bit;
      logic [LPWM_CHANNELS-1:0][7:0]     duty_sh;
      logic [LPWM_CHANNELS-1:0][7:0]     duty_act;
      logic [LPWM_CHANNELS-1:0][5:0]     scale_sh;
      logic [LPWM_CHANNELS-1:0][5:0]     scale_act;
      logic [LPWM_CHANNELS-1:0]          led;
      logic [LPWM_CHANNELS-1:0][1:0]     current_scale_code;
   } lpwm_state_type;
endpackage

// ===== lpwm_tick.sv
`timescale 1ns/10ps
module lpwm_tick
   import lpwm_pkg::*;
(
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   // rate choice
   input  wire logic       i_rate_select_bit,
   // step count
   output logic [7:0]      o_cnt,
   output logic            o_wrap
);
   lpwm_tick_state_type st;
   lpwm_tick_state_type next_st;
   logic [7:0]          limit;

   // ==========================================================
   // divider and free-running 256-step counter
   always_comb
   begin
      next_st      = st;
      next_st.wrap = 1'b0;
      limit        = i_rate_select_bit ? 8'(STEP_SLOW_CYCLES - 1) : 8'(STEP_FAST_CYCLES - 1);
      if (st.div >= limit)
      begin
         next_st.div  = 8'h00;
         next_st.cnt  = st.cnt + 8'h01;
         next_st.wrap = (st.cnt == 8'hFF);
      end
      else
      begin
         next_st.div = st.div + 8'h01;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_cnt  = st.cnt;
   assign o_wrap = st.wrap;
endmodule

// ===== lpwm_regs.sv
// Behaviour
// - shutdown_control bit 0 holds soft_off_n, other bits unused, reset zero.
// - twelve 8-bit duty registers at 04h..0Fh, one per channel, reset zero.
// - each output is on for duty/256 of every pwm period.
// - duty and scale writes are staged; zero written to 13h makes them active.
// - scale code 10h..13h turns channel on with a scale; 00xxxx is off.
// - global_output_control bit 0 forces all outputs off, reset zero.
// - pwm_rate_select bit 0: 0 gives 24kHz, 1 gives 3.6kHz.
// - zero written to 2Fh returns every register to its default.
// - after power-up all registers hold defaults and outputs are dark.
// - registers are write-only; there is no read path.
// - soft_off_n low turns all outputs off; high allows normal operation.
// - shutdown keeps every register value unchanged.
// - hw_off_n_pin low turns all outputs off.
// - the register pointer steps by one after each accepted data byte.
`timescale 1ns/10ps
module lpwm_regs
   import lpwm_pkg::*;
#(
   parameter int NCH = LPWM_CHANNELS
)
(
   // clock and reset
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst_n,
   // register write port: address byte, then data bytes
   input  wire logic                 i_addr_valid,
   input  wire logic [7:0]           i_addr,
   input  wire logic                 i_data_valid,
   input  wire logic [7:0]           i_data,
   // shutdown pin
   input  wire logic                 i_hw_off_n_pin,
   // led sink outputs
   output logic [NCH-1:0]            o_led_sink_outputs,
   output logic [NCH-1:0][1:0]       o_current_scale_code
);
   lpwm_state_type st;
   lpwm_state_type next_st;
   logic [7:0]     cnt;
   logic           wrap;
   logic           wr;
   logic           hit_duty;
   logic           hit_scale;
   logic           hit_load;
   logic           hit_reset;
   logic           mapped;
   logic [7:0]     duty_idx;
   logic [7:0]     scale_idx;
   logic           run;

   // ==========================================================
   // shared step counter
   lpwm_tick u_tick (
      .i_mclk            (i_mclk),
      .i_rst_n           (i_rst_n),
      .i_rate_select_bit (st.rate_select_bit),
      .o_cnt             (cnt),
      .o_wrap            (wrap)
   );

   // ==========================================================
   // address decode of the pointer
   assign wr        = i_data_valid && !i_addr_valid;
   assign duty_idx  = st.ptr - OFS_CHANNEL_DUTY;
   assign scale_idx = st.ptr - OFS_CURRENT_SELECT;
   // only mapped offsets select a register; any other offset falls through untouched
   assign hit_duty  = st.ptr >= OFS_CHANNEL_DUTY && st.ptr <= OFS_DUTY_LAST;
   assign hit_scale = st.ptr >= OFS_CURRENT_SELECT && st.ptr <= OFS_SELECT_LAST;
   assign hit_load  = wr && st.ptr == OFS_SHADOW_LOAD && i_data == TRIGGER_VALUE;
   assign hit_reset = wr && st.ptr == OFS_SOFT_RESET && i_data == TRIGGER_VALUE;
   assign mapped    = hit_duty || hit_scale || st.ptr == OFS_SHUTDOWN_CONTROL ||
                      st.ptr == OFS_SHADOW_LOAD || st.ptr == OFS_GLOBAL_OUTPUT ||
                      st.ptr == OFS_PWM_RATE_SELECT || st.ptr == OFS_SOFT_RESET;
   // outputs may run only when no shutdown source is active
   assign run       = st.soft_off_n && i_hw_off_n_pin && !st.global_off;

   // ==========================================================
   // register writes, staging and output compare
   always_comb
   begin
      next_st = st;
      if (i_addr_valid)
      begin
         next_st.ptr = i_addr;
      end
      else if (wr)
      begin
         next_st.ptr = st.ptr + 8'h01;
         if (st.ptr == OFS_SHUTDOWN_CONTROL)
         begin
            next_st.soft_off_n = i_data[BIT_SOFT_OFF_N];
         end
         if (st.ptr == OFS_GLOBAL_OUTPUT)
         begin
            next_st.global_off = i_data[BIT_GLOBAL_OFF];
         end
         if (st.ptr == OFS_PWM_RATE_SELECT)
         begin
            next_st.rate_select_bit = i_data[BIT_RATE_SELECT];
         end
         if (hit_duty)
         begin
            next_st.duty_sh[duty_idx[3:0]] = i_data;
         end
         if (hit_scale)
         begin
            next_st.scale_sh[scale_idx[3:0]] = i_data[SCALE_WIDTH-1:0];
         end
         if (hit_load)
         begin
            next_st.duty_act  = st.duty_sh;
            next_st.scale_act = st.scale_sh;
         end
         if (hit_reset)
         begin
            next_st.soft_off_n      = RESET_SOFT_OFF_N;
            next_st.global_off      = RESET_GLOBAL_OFF;
            next_st.rate_select_bit = RESET_RATE_SELECT;
            next_st.duty_sh         = {NCH{RESET_DUTY}};
            next_st.duty_act        = {NCH{RESET_DUTY}};
            next_st.scale_sh        = {NCH{RESET_SCALE}};
            next_st.scale_act       = {NCH{RESET_SCALE}};
         end
      end
      // compare per channel; codes 1xxxxx are not allowed and stay dark
      for (int i = 0; i < NCH; i++)
      begin
         next_st.led[i] = run && st.scale_act[i][5:4] == SCALE_ON_TOP &&
                          st.duty_act[i] > cnt;
         next_st.current_scale_code[i] = st.scale_act[i][1:0];
      end
   end

   // registers: defaults at power-up, no read path exists
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_led_sink_outputs   = st.led;
   assign o_current_scale_code = st.current_scale_code;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   // shutdown sources darken the outputs and keep duty_sh, duty_act and scale_act
   AST_SOFT_OFF_DARK: assert property (
      !st.soft_off_n |=> o_led_sink_outputs == '0)
      else $error("output on during software shutdown");

   AST_HW_OFF_DARK: assert property (
      !i_hw_off_n_pin |=> o_led_sink_outputs == '0)
      else $error("output on while shutdown pin low");

   AST_GLOBAL_OFF_DARK: assert property (
      st.global_off |=> o_led_sink_outputs == '0)
      else $error("output on while global off set");

   AST_RETAIN_OFF: assert property (
      !run && !wr |=> $stable(st.duty_sh) && $stable(st.duty_act) && $stable(st.scale_act))
      else $error("register changed during shutdown without a write");

   // pwm compare against the shared step count
   AST_DUTY_COMPARE: assert property (
      o_led_sink_outputs[0] |-> $past(st.duty_act[0]) > $past(cnt))
      else $error("channel on beyond its duty");

   AST_FULL_ON: assert property (
      run && st.scale_act[0][5:4] == SCALE_ON_TOP && st.duty_act[0] > cnt
         |=> o_led_sink_outputs[0])
      else $error("channel dark inside its duty");

   AST_OFF_CODE: assert property (
      st.scale_act[1][5:4] != SCALE_ON_TOP |=> !o_led_sink_outputs[1])
      else $error("channel on with off scale code");

   AST_PERIOD_WRAP: assert property (
      wrap |-> cnt == 8'h00)
      else $error("period wrap without count at zero");

   // staging and the two trigger registers
   AST_LOAD_COPIES: assert property (
      hit_load && !hit_reset |=> st.duty_act == $past(st.duty_sh) &&
         st.scale_act == $past(st.scale_sh))
      else $error("update write did not copy staged values");

   AST_ACTIVE_HOLDS: assert property (
      !hit_load && !hit_reset |=> $stable(st.duty_act) && $stable(st.scale_act))
      else $error("active values changed without update");

   AST_SOFT_RESET: assert property (
      hit_reset |=> !st.soft_off_n && st.duty_sh == '0 && st.scale_act == '0 &&
         !st.rate_select_bit)
      else $error("reset write left a register set");

   // pointer and plain register writes
   AST_PTR_STEP: assert property (
      wr |=> st.ptr == $past(st.ptr) + 8'h01)
      else $error("pointer did not step after data byte");

   AST_ADDR_LOADS: assert property (
      i_addr_valid |=> st.ptr == $past(i_addr))
      else $error("address byte did not load the pointer");

   AST_SHUTDOWN_WRITE: assert property (
      wr && st.ptr == OFS_SHUTDOWN_CONTROL |=> st.soft_off_n == $past(i_data[BIT_SOFT_OFF_N]))
      else $error("shutdown write did not land");

   AST_RATE_WRITE: assert property (
      wr && st.ptr == OFS_PWM_RATE_SELECT
         |=> st.rate_select_bit == $past(i_data[BIT_RATE_SELECT]))
      else $error("rate select write did not land");

   AST_UNMAPPED: assert property (
      wr && !mapped |=> $stable(st.duty_sh) && $stable(st.scale_sh) &&
         $stable(st.soft_off_n) && $stable(st.global_off) && $stable(st.rate_select_bit))
      else $error("unmapped write changed a register");
endmodule

// ===== lpwm_host.sv
`timescale 1ns/10ps
module lpwm_host
   import lpwm_pkg::*;
(
   // clock
   input  wire logic       i_mclk,
   // register write port
   output logic            o_addr_valid,
   output logic [7:0]      o_addr,
   output logic            o_data_valid,
   output logic [7:0]      o_data
);
   // ==========================================================
   // byte driver, changes only at the falling edge
   initial
   begin
      o_addr_valid = 1'b0;
      o_addr       = 8'h00;
      o_data_valid = 1'b0;
      o_data       = 8'h00;
   end
   // address byte, then one data byte, or two back to back when n > 1
   task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
                     input int n);
      @(negedge i_mclk);
      o_addr_valid = 1'b1;
      o_addr       = a;
      @(negedge i_mclk);
      o_addr_valid = 1'b0;
      o_addr       = ~a; // released byte shows no stale value
      o_data_valid = 1'b1;
      o_data       = d0;
      if (n > 1)
      begin
         @(negedge i_mclk);
         o_data    = d1;
      end
      @(negedge i_mclk);
      o_data_valid = 1'b0;
      o_data       = ~o_data;
   endtask
   // zero to a trigger offset; only zero is a legal trigger
   task automatic trig(input logic [7:0] a);
      wr(a, TRIGGER_VALUE, 8'h00, 1);
   endtask
endmodule

// ===== lpwm_regs_tb.sv
`timescale 1ns/10ps
module lpwm_regs_tb;
   import lpwm_pkg::*;
   // ==========================================================
   // clock, reset, wiring
   logic                   i_mclk = 1'b0;
   logic                   i_rst_n = 1'b0;
   logic                   i_hw_off_n_pin = 1'b1;
   logic                   av, dv;
   logic [7:0]             ad, dd;
   logic [11:0]            led;
   logic [11:0][1:0]       scl;
   int                     fails = 0;
   int                     checks_done = 0;
   localparam int          PF = STEP_FAST_CYCLES * LPWM_STEPS;
   localparam int          PS = STEP_SLOW_CYCLES * LPWM_STEPS;
   always #25 i_mclk = ~i_mclk;
   lpwm_host host (.i_mclk(i_mclk), .o_addr_valid(av), .o_addr(ad), .o_data_valid(dv),
                   .o_data(dd));
   lpwm_regs dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr_valid(av), .i_addr(ad),
                  .i_data_valid(dv), .i_data(dd), .i_hw_off_n_pin(i_hw_off_n_pin),
                  .o_led_sink_outputs(led), .o_current_scale_code(scl));
   // ==========================================================
   // comparison and verdict
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // on-cycles of one channel over a window, after outputs settle
   task automatic meas(input int ch, input int len, input int e, input string n);
      logic [31:0] c;
      c = 32'h0;
      repeat (4) @(negedge i_mclk);
      repeat (len)
      begin
         @(negedge i_mclk);
         c = c + 32'(led[ch]); // an unknown output spoils the whole count
      end
      chk(n, e, c);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_stage;
      host.wr(OFS_CHANNEL_DUTY, 8'h80, 8'h00, 1);
      host.wr(OFS_CURRENT_SELECT, 8'h10, 8'h00, 1);
      host.wr(OFS_SHUTDOWN_CONTROL, 8'h01, 8'h00, 1);
      meas(0, PF, 0, "staged");
      host.trig(OFS_SHADOW_LOAD);
      meas(0, PF, 128 * STEP_FAST_CYCLES, "duty fast");
      host.wr(OFS_PWM_RATE_SELECT, 8'h01, 8'h00, 1);
      meas(0, PS, 128 * STEP_SLOW_CYCLES, "duty slow");
      host.wr(OFS_PWM_RATE_SELECT, 8'h00, 8'h00, 1);
      $display("test stage done");
   endtask
   task automatic t_scale;
      for (int k = 0; k < 4; k++)
      begin
         host.wr(OFS_CURRENT_SELECT, 8'h13 - 8'(k), 8'h00, 1);
         host.trig(OFS_SHADOW_LOAD);
         repeat (3) @(negedge i_mclk);
         chk("scale", 32'(3 - k), 32'(scl[0]));
      end
      host.wr(OFS_CURRENT_SELECT, 8'h0F, 8'h00, 1);
      host.trig(OFS_SHADOW_LOAD);
      meas(0, PF, 0, "scale off");
      host.wr(OFS_CURRENT_SELECT, 8'h10, 8'h00, 1);
      host.trig(OFS_SHADOW_LOAD);
      $display("test scale done");
   endtask
   task automatic t_off;
      host.wr(OFS_GLOBAL_OUTPUT, 8'h01, 8'h00, 1);
      meas(0, PF, 0, "global off");
      host.wr(OFS_GLOBAL_OUTPUT, 8'h00, 8'h00, 1);
      @(negedge i_mclk);
      i_hw_off_n_pin = 1'b0;
      meas(0, PF, 0, "pin off");
      i_hw_off_n_pin = 1'b1;
      host.wr(OFS_SHUTDOWN_CONTROL, 8'h00, 8'h00, 1);
      meas(0, PF, 0, "soft off");
      host.wr(OFS_SHUTDOWN_CONTROL, 8'h01, 8'h00, 1);
      meas(0, PF, 128 * STEP_FAST_CYCLES, "retained");
      $display("test off done");
   endtask
   task automatic t_burst;
      host.wr(OFS_CHANNEL_DUTY, 8'h40, 8'h20, 2);
      host.wr(OFS_CURRENT_SELECT + 8'h01, 8'h10, 8'h00, 1);
      host.trig(OFS_SHADOW_LOAD);
      meas(1, PF, 32 * STEP_FAST_CYCLES, "burst ch2");
      host.wr(8'h30, 8'hFF, 8'hFF, 2);
      host.trig(OFS_SHADOW_LOAD);
      meas(0, PF, 64 * STEP_FAST_CYCLES, "unmapped");
      host.trig(OFS_SOFT_RESET);
      host.wr(OFS_SHUTDOWN_CONTROL, 8'h01, 8'h00, 1);
      meas(0, PF, 0, "soft reset");
      $display("test burst done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      repeat (8) @(negedge i_mclk);
      chk("reset dark", 32'h0, 32'(led));
      i_rst_n = 1'b1;
      t_stage();
      t_scale();
      t_off();
      t_burst();
      summarize();
   end
   initial
   begin
      #2ms;
      fails++;
      summarize();
   end
endmodule
